// File: hw/ccir_pkg.sv
// shared constants and types for the cycle and interrupt-return control core
package ccir_pkg;
   // one instruction cycle is four system clocks, phases 0..3
   localparam logic [1:0] PHASE_LAST = 2'h3;
   localparam int PC_W = 10;
   localparam int STACK_DEPTH = 4;
   localparam logic [2:0] STACK_FULL = 3'h4;
   localparam int NUM_SRC = 4;
   localparam int GROUP_IDX = 3;
   localparam int NUM_MEMBER = 2;
   localparam logic [PC_W-1:0] RESET_PC = 10'h000;
   localparam logic [PC_W-1:0] VEC_BASE = 10'h004;

   // data memory locations with a special meaning
   localparam logic [7:0] MEM_PC_LO = 8'h02;
   localparam logic [7:0] MEM_TBL_LO = 8'h07;
   localparam logic [7:0] MEM_TBL_HI = 8'h08;
   localparam logic [7:0] MEM_TBL_OUT = 8'h09;

   // register port offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_IRQ_EN = 8'h01;
   localparam logic [7:0] REG_IRQ_FLAG = 8'h02;
   localparam logic [7:0] REG_MEMBER = 8'h03;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_WORK = 8'h05;
   localparam logic [7:0] REG_PC_LO = 8'h06;
   localparam logic [7:0] REG_PC_HI = 8'h07;
   localparam int CTRL_GIE_BIT = 0;
   localparam int CTRL_SLEEP_BIT = 1;
   localparam logic GIE_RESET = 1'b0;
   localparam logic [NUM_SRC-1:0] EN_RESET = 4'h0;

   // instruction word: [15:12] opcode, [11:8] sub field, [7:0] address or data
   localparam logic [3:0] OP_MISC = 4'h0;
   localparam logic [3:0] OP_MOV_A_M = 4'h1;
   localparam logic [3:0] OP_MOV_M_A = 4'h2;
   localparam logic [3:0] OP_MOV_A_X = 4'h3;
   localparam logic [3:0] OP_ALU_A = 4'h4;
   localparam logic [3:0] OP_ALU_M = 4'h5;
   localparam logic [3:0] OP_ALU_X = 4'h6;
   localparam logic [3:0] OP_SET = 4'h7;
   localparam logic [3:0] OP_CLR = 4'h8;
   localparam logic [3:0] OP_SKZ = 4'h9;
   localparam logic [3:0] OP_SKBZ = 4'ha;
   localparam logic [3:0] OP_SKBNZ = 4'hb;
   localparam logic [3:0] OP_JMP = 4'hc;
   localparam logic [3:0] OP_CALL = 4'hd;
   localparam logic [3:0] OP_TBL = 4'he;
   localparam logic [3:0] MISC_RET = 4'h1;
   localparam logic [3:0] MISC_INTERRUPT_EXIT_OP = 4'h2;
   localparam logic [3:0] MISC_HALT = 4'h3;

   typedef enum logic [3:0] {
      ALU_ADD = 4'h0,
      ALU_ADC = 4'h1,
      ALU_SUB = 4'h2,
      ALU_SBC = 4'h3,
      ALU_AND = 4'h4,
      ALU_OR = 4'h5,
      ALU_XOR = 4'h6,
      ALU_CPL = 4'h7,
      ALU_INC = 4'h8,
      ALU_DEC = 4'h9,
      ALU_RR = 4'ha,
      ALU_RL = 4'hb,
      ALU_RRC = 4'hc,
      ALU_RLC = 4'hd,
      ALU_PASS = 4'he
   } ccir_alu_type;

   typedef enum logic {
      MODE_RUN = 1'b0,
      MODE_SLEEP = 1'b1
   } ccir_mode_type;
endpackage

// File: hw/ccir_alu.sv
// arithmetic, logic and rotate unit of the core
`timescale 1ns/1ns
module ccir_alu
   import ccir_pkg::*;
(
   input wire logic [7:0] acc,
   input wire logic [7:0] opnd,
   input wire logic carry_in,
   input wire ccir_alu_type func,
   output logic [7:0] result,
   output logic carry_out,
   output logic zero,
   output logic sets_carry,
   output logic sets_zero
);
   wire is_sub = (func == ALU_SUB) || (func == ALU_SBC);
   wire with_c = (func == ALU_ADC) || (func == ALU_SBC);
   wire cin = with_c ? carry_in : is_sub;
   wire [7:0] rhs = is_sub ? ~opnd : opnd;
   // one adder for both: carry out of a subtract is the inverse of borrow
   wire [8:0] sum = {1'b0, acc} + {1'b0, rhs} + {8'h00, cin};

   always_comb begin
      result = sum[7:0];
      carry_out = sum[8];
      case (func)
         ALU_AND: result = acc & opnd;
         ALU_OR: result = acc | opnd;
         ALU_XOR: result = acc ^ opnd;
         ALU_CPL: result = ~opnd;
         ALU_INC: result = opnd + 8'h01;
         ALU_DEC: result = opnd - 8'h01;
         ALU_RR: result = {opnd[0], opnd[7:1]};
         ALU_RL: result = {opnd[6:0], opnd[7]};
         ALU_RRC: begin
            result = {carry_in, opnd[7:1]};
            carry_out = opnd[0];
         end
         ALU_RLC: begin
            result = {opnd[6:0], carry_in};
            carry_out = opnd[7];
         end
         ALU_PASS: result = opnd;
         default: result = sum[7:0];
      endcase
   end

   assign sets_carry = (func <= ALU_SBC) || (func == ALU_RRC) || (func == ALU_RLC);
   // all rotates, plain and through carry, and pass leave the zero flag alone
   assign sets_zero = (func <= ALU_DEC);
   assign zero = (result == 8'h00);
endmodule

// File: hw/ccir_core.sv
// instruction cycle, interrupt entry and return control of the core
// How it works
// - a set request flag stays set until serviced or cleared by software
// - servicing the group clears only the group flag, members stay set
// - in sleep any request flag rising from low to high starts a wake-up
// - that wake-up ignores every interrupt enable bit
// - interrupt entry pushes only the program counter
// - interrupt entry clears the global enable
// - vector call only when enabled and the stack is not full
// - interrupt return pops the address and sets the global enable
// - subroutine return pops the address and leaves the global enable alone
// - each instruction cycle lasts exactly four system clocks
// - most instructions take one cycle; jump, call, returns, table read take two
// - a write to the program counter low byte acts as a jump, one cycle more
// - a skip costs one cycle, plus one more when the skip is taken
// - transfers: memory to working, working to memory, immediate to working
// - add and subtract leave carry and borrow status
// - increment and decrement change by one, to memory or working
// - logic operations set the zero flag on a zero result
// - rotates move one bit; through-carry forms pass the bit via carry
// - call saves the next address, return resumes there, jump saves nothing; a call on a full stack jumps without saving
// - conditional branches test a byte or a bit and skip or proceed
// - bit set and clear rewrite only the selected bit
// - table read copies a program memory word into data memory
//
// The implementer's own choices: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
module ccir_core
   import ccir_pkg::*;
(
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   output logic [PC_W-1:0] prog_addr,
   input wire logic [15:0] prog_data,
   input wire logic [2:0] src_event,
   input wire logic [NUM_MEMBER-1:0] member_event,
   output logic core_asleep
);
   function automatic logic [7:0] bit_mask(input logic [2:0] idx);
      bit_mask = 8'h01 << idx;
   endfunction

   function automatic logic [1:0] first_pending(input logic [NUM_SRC-1:0] p);
      first_pending = 2'h0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (p[i]) begin
            first_pending = 2'(i);
         end
      end
   endfunction

   logic [1:0] phase_q;
   ccir_mode_type mode_q;
   ccir_mode_type mode_d;
   logic [PC_W-1:0] pc_q;
   logic [PC_W-1:0] pc_d;
   logic [PC_W-1:0] fetch_q;
   logic [15:0] ir_q;
   logic ir_valid_q;
   logic tbl_q;
   logic [7:0] tbl_dst_q;
   logic [7:0] work_q;
   logic [7:0] work_d;
   logic carry_q;
   logic zero_q;
   logic gie_q;
   logic gie_d;
   logic [NUM_SRC-1:0] en_q;
   logic [NUM_SRC-1:0] flag_q;
   logic [NUM_SRC-1:0] flag_prev_q;
   logic [NUM_MEMBER-1:0] member_q;
   logic [PC_W-1:0] stack_q [0:STACK_DEPTH-1];
   logic [2:0] depth_q;
   logic [7:0] data_mem [0:255];
   logic [7:0] rdata_q;
   logic [7:0] alu_res;
   logic alu_carry;
   logic alu_zero;
   logic alu_sets_c;
   logic alu_sets_z;

   // bus decode
   wire bus_wr_ctrl = reg_wr && (reg_addr == REG_CTRL);
   wire bus_wr_en = reg_wr && (reg_addr == REG_IRQ_EN);
   wire bus_wr_flag = reg_wr && (reg_addr == REG_IRQ_FLAG);
   wire bus_wr_member = reg_wr && (reg_addr == REG_MEMBER);

   // instruction decode
   wire cyc_end = (phase_q == PHASE_LAST);
   wire running = (mode_q == MODE_RUN);
   wire [3:0] op = ir_q[15:12];
   wire [3:0] sub = ir_q[11:8];
   wire [7:0] fld = ir_q[7:0];
   wire [PC_W-1:0] target = ir_q[PC_W-1:0];

   // interrupt request selection
   wire [NUM_SRC-1:0] pend = flag_q & en_q;
   wire stack_full = (depth_q == STACK_FULL);
   wire [1:0] irq_idx = first_pending(pend);
   wire slot_ok = cyc_end && running && ir_valid_q && !tbl_q;
   wire take_irq = slot_ok && gie_q && (|pend) && !stack_full;
   wire exec = slot_ok && !take_irq;
   wire tbl_done = cyc_end && running && tbl_q;
   wire [PC_W-1:0] vector = VEC_BASE + {6'h00, irq_idx, 2'h0};

   wire is_ret = exec && (op == OP_MISC) && (sub == MISC_RET);
   wire is_interrupt_exit_op = exec && (op == OP_MISC) && (sub == MISC_INTERRUPT_EXIT_OP);
   wire is_halt = exec && (op == OP_MISC) && (sub == MISC_HALT);
   wire is_jmp = exec && (op == OP_JMP);
   wire is_call = exec && (op == OP_CALL);
   wire is_tbl = exec && (op == OP_TBL);
   wire is_mov_m = exec && (op == OP_MOV_M_A);
   wire is_alu_m = exec && (op == OP_ALU_M);
   wire is_set = exec && (op == OP_SET);
   wire is_clr = exec && (op == OP_CLR);
   wire is_alu = exec && ((op == OP_ALU_A) || is_alu_m || (op == OP_ALU_X));

   // operand fetch; the low program counter byte reads back through memory
   wire [7:0] mem_val = (fld == MEM_PC_LO) ? pc_q[7:0] : data_mem[fld];
   wire [7:0] sel_mask = bit_mask(sub[2:0]);
   wire [7:0] sel_bits = mem_val & sel_mask;
   wire [7:0] alu_opnd = (op == OP_ALU_X) ? fld : mem_val;

   ccir_alu u_alu (
      .acc(work_q),
      .opnd(alu_opnd),
      .carry_in(carry_q),
      .func(ccir_alu_type'(sub)),
      .result(alu_res),
      .carry_out(alu_carry),
      .zero(alu_zero),
      .sets_carry(alu_sets_c),
      .sets_zero(alu_sets_z)
   );

   // memory write back
   wire mem_we = is_mov_m || is_alu_m || is_set || is_clr;
   wire [7:0] mem_wval = is_mov_m ? work_q :
      is_alu_m ? alu_res :
      is_set ? (mem_val | sel_mask) :
      (mem_val & ~sel_mask);
   wire pcl_write = mem_we && (fld == MEM_PC_LO);
   wire skip_taken = exec && (((op == OP_SKZ) && (mem_val == 8'h00)) ||
      ((op == OP_SKBZ) && (sel_bits == 8'h00)) ||
      ((op == OP_SKBNZ) && (sel_bits != 8'h00)));
   // every path that moves the counter off its sequence costs one cycle
   wire redirect = take_irq || is_jmp || is_call || is_ret || is_interrupt_exit_op ||
      pcl_write || skip_taken;

   // stack
   wire [1:0] top_idx = (depth_q == 3'h0) ? 2'h0 : 2'(depth_q - 3'h1);
   wire [PC_W-1:0] stack_top = stack_q[top_idx];
   wire push = take_irq || (is_call && !stack_full);
   wire pop = (is_ret || is_interrupt_exit_op) && (depth_q != 3'h0);
   // the held instruction was not run, so the interrupt returns to it
   wire [PC_W-1:0] push_val = take_irq ? (pc_q - 10'h001) : pc_q;
   wire [PC_W-1:0] tbl_ptr = {data_mem[MEM_TBL_HI][1:0], data_mem[MEM_TBL_LO]};

   // flags
   wire [NUM_SRC-1:0] flag_set = {|member_event, src_event};
   wire [NUM_SRC-1:0] flag_rise = flag_q & ~flag_prev_q;
   logic [NUM_SRC-1:0] flag_clr;

   always_comb begin
      pc_d = pc_q;
      if (take_irq) begin
         pc_d = vector;
      end else if (is_jmp || is_call) begin
         pc_d = target;
      end else if (is_ret || is_interrupt_exit_op) begin
         pc_d = stack_top;
      end else if (pcl_write) begin
         pc_d = {pc_q[PC_W-1:8], mem_wval};
      end else if (cyc_end && running && !tbl_q) begin
         pc_d = pc_q + 10'h001;
      end
   end

   always_comb begin
      work_d = work_q;
      if (exec && (op == OP_MOV_A_M)) begin
         work_d = mem_val;
      end else if (exec && (op == OP_MOV_A_X)) begin
         work_d = fld;
      end else if (is_alu && !is_alu_m) begin
         work_d = alu_res;
      end
   end

   always_comb begin
      gie_d = gie_q;
      if (take_irq) begin
         gie_d = 1'b0;
      end else if (is_interrupt_exit_op) begin
         gie_d = 1'b1;
      end else if (is_ret) begin
         gie_d = gie_q;
      end else if (bus_wr_ctrl) begin
         gie_d = reg_wdata[CTRL_GIE_BIT];
      end
   end

   always_comb begin
      mode_d = mode_q;
      if (!running && (|flag_rise)) begin
         mode_d = MODE_RUN;
      end else if (is_halt || (running && bus_wr_ctrl && reg_wdata[CTRL_SLEEP_BIT])) begin
         mode_d = MODE_SLEEP;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         phase_q <= 2'h0;
      end else begin
         phase_q <= phase_q + 2'h1;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         pc_q <= RESET_PC;
         fetch_q <= RESET_PC;
         ir_q <= 16'h0000;
         ir_valid_q <= 1'b0;
         tbl_q <= 1'b0;
         tbl_dst_q <= 8'h00;
      end else if (cyc_end && running) begin
         pc_q <= pc_d;
         fetch_q <= is_tbl ? tbl_ptr : pc_d;
         tbl_q <= is_tbl;
         if (is_tbl) begin
            tbl_dst_q <= fld;
         end
         if (!tbl_q) begin
            ir_q <= prog_data;
            ir_valid_q <= !redirect;
         end
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         work_q <= 8'h00;
         carry_q <= 1'b0;
         zero_q <= 1'b0;
         gie_q <= GIE_RESET;
         en_q <= EN_RESET;
         mode_q <= MODE_RUN;
         member_q <= '0;
         flag_prev_q <= '0;
      end else begin
         work_q <= work_d;
         gie_q <= gie_d;
         mode_q <= mode_d;
         flag_prev_q <= flag_q;
         if (is_alu && alu_sets_c) begin
            carry_q <= alu_carry;
         end
         if (is_alu && alu_sets_z) begin
            zero_q <= alu_zero;
         end
         if (bus_wr_en) begin
            en_q <= reg_wdata[NUM_SRC-1:0];
         end
         // a member event in the clearing cycle survives the clear
         member_q <= member_event |
            (member_q & ~(bus_wr_member ? reg_wdata[NUM_MEMBER-1:0] : '0));
      end
   end

   genvar g;
   generate
      for (g = 0; g < NUM_SRC; g++) begin : g_flag
         // servicing clears only this flag; the set term wins over any clear
         assign flag_clr[g] = (bus_wr_flag && reg_wdata[g]) ||
            (take_irq && (irq_idx == 2'(g)));
         always_ff @(posedge clock) begin
            if (sys_rst) begin
               flag_q[g] <= 1'b0;
            end else begin
               flag_q[g] <= flag_set[g] || (flag_q[g] && !flag_clr[g]);
            end
         end
      end
   endgenerate

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         depth_q <= 3'h0;
      end else if (push) begin
         depth_q <= depth_q + 3'h1;
      end else if (pop) begin
         depth_q <= depth_q - 3'h1;
      end
   end

   // contents carry no reset, only the depth does
   always_ff @(posedge clock) begin
      if (push) begin
         stack_q[depth_q[1:0]] <= push_val;
      end
   end

   always_ff @(posedge clock) begin
      if (mem_we && !pcl_write) begin
         data_mem[fld] <= mem_wval;
      end
      if (tbl_done) begin
         data_mem[tbl_dst_q] <= prog_data[7:0];
         data_mem[MEM_TBL_OUT] <= prog_data[15:8];
      end
   end

   // register read port
   wire [7:0] status_word = {1'b0, depth_q, 1'b0, zero_q, carry_q, !running};
   wire [7:0] rd_word = (reg_addr == REG_CTRL) ? {7'h00, gie_q} :
      (reg_addr == REG_IRQ_EN) ? {4'h0, en_q} :
      (reg_addr == REG_IRQ_FLAG) ? {4'h0, flag_q} :
      (reg_addr == REG_MEMBER) ? {6'h00, member_q} :
      (reg_addr == REG_STATUS) ? status_word :
      (reg_addr == REG_WORK) ? work_q :
      (reg_addr == REG_PC_LO) ? pc_q[7:0] :
      (reg_addr == REG_PC_HI) ? {6'h00, pc_q[PC_W-1:8]} : 8'h00;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rdata_q <= 8'h00;
      end else begin
         rdata_q <= reg_rd ? rd_word : 8'h00;
      end
   end

   assign reg_rdata = rdata_q;
   assign prog_addr = fetch_q;
   assign core_asleep = mode_q;

   wire [NUM_SRC-1:0] flag_keep = flag_q & ~flag_clr;

   a_phase_len: assert property (@(posedge clock) disable iff (sys_rst)
      cyc_end |=> !cyc_end [*3] ##1 cyc_end)
      else $error("instruction cycle is not four clocks");
   a_flag_sticky: assert property (@(posedge clock) disable iff (sys_rst)
      1'b1 |=> (flag_q & $past(flag_keep)) == $past(flag_keep))
      else $error("request flag dropped without service or clear");
   a_group_members: assert property (@(posedge clock) disable iff (sys_rst)
      take_irq && (irq_idx == 2'(GROUP_IDX)) && !bus_wr_member
      |=> !flag_q[GROUP_IDX] || $past(|member_event) ##0
         ((member_q & $past(member_q)) == $past(member_q)))
      else $error("group service disturbed member flags");
   a_wake_rise: assert property (@(posedge clock) disable iff (sys_rst)
      (mode_q == MODE_SLEEP) && (|flag_rise) |=> (mode_q == MODE_RUN))
      else $error("rising flag did not wake the core");
   a_wake_only_rise: assert property (@(posedge clock) disable iff (sys_rst)
      (mode_q == MODE_SLEEP) && (flag_rise == '0) |=> (mode_q == MODE_SLEEP))
      else $error("core woke without a rising flag");
   a_irq_entry: assert property (@(posedge clock) disable iff (sys_rst)
      take_irq |=> !gie_q && (depth_q == $past(depth_q) + 3'h1) && (pc_q == $past(vector)))
      else $error("interrupt entry did not push and disable");
   a_full_block: assert property (@(posedge clock) disable iff (sys_rst)
      stack_full || !gie_q |-> !take_irq)
      else $error("vector call taken while not allowed");
   a_interrupt_exit_op_gie: assert property (@(posedge clock) disable iff (sys_rst)
      is_interrupt_exit_op |=> gie_q && (pc_q == $past(stack_top)))
      else $error("interrupt return did not re-enable");
   a_ret_gie: assert property (@(posedge clock) disable iff (sys_rst)
      is_ret && !bus_wr_ctrl |=> (gie_q == $past(gie_q)))
      else $error("subroutine return changed the global enable");
   a_jump_cycles: assert property (@(posedge clock) disable iff (sys_rst)
      is_jmp |=> !ir_valid_q [*4] ##0 (pc_q == $past(target, 4)) ##4 ir_valid_q)
      else $error("jump did not take two cycles");
   a_skip_drop: assert property (@(posedge clock) disable iff (sys_rst)
      skip_taken |=> !ir_valid_q)
      else $error("taken skip kept the fetched instruction");
   a_pcl_jump: assert property (@(posedge clock) disable iff (sys_rst)
      pcl_write |=> !ir_valid_q && (pc_q[7:0] == $past(mem_wval)))
      else $error("low counter write did not act as a jump");
endmodule

// File: tb/test_ccir_core.sv
// self-checking bench for the cycle and interrupt-return control core
`timescale 1ns/1ns
module test_ccir_core
   import ccir_pkg::*;
();
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   logic [7:0] reg_addr = 8'h00;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata;
   logic [PC_W-1:0] prog_addr;
   logic [15:0] prog_data = 16'h0000;
   logic [2:0] src_event = 3'h0;
   logic [NUM_MEMBER-1:0] member_event = '0;
   logic core_asleep;
   logic [15:0] prog [0:1023];
   int miscompares = 0;
   int compares = 0;

   always #20 clock = ~clock;
   // registered lookup is safe: the word is only sampled at the cycle end, four edges on
   always @(posedge clock) prog_data <= prog[prog_addr];

   ccir_core uut (
      .clock(clock),
      .sys_rst(sys_rst),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .prog_addr(prog_addr),
      .prog_data(prog_data),
      .src_event(src_event),
      .member_event(member_event),
      .core_asleep(core_asleep)
   );

   task end_sim;
      $display("miscompares %0d compares %0d", miscompares, compares);
      if (miscompares == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task chk(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("FAIL at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
      #1;
   endtask

   task rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1;
      chk({8'h00, reg_rdata & m}, {8'h00, e});
   endtask

   // counts edges until the fetch address shows a; e of zero skips the count check
   task wait_pc(input logic [PC_W-1:0] a, input int e);
      int n;
      n = 0;
      while (prog_addr !== a && n < 20) begin
         @(posedge clock);
         #1;
         n++;
      end
      if (prog_addr !== a) begin
         chk({6'h00, prog_addr}, {6'h00, a});
         end_sim;
      end
      if (e != 0) begin
         chk(n[15:0], e[15:0]);
      end
   endtask

   task wait_sleep(input logic v);
      int n;
      n = 0;
      while (core_asleep !== v && n < 20) begin
         @(posedge clock);
         #1;
         n++;
      end
      chk({15'h0000, core_asleep}, {15'h0000, v});
      if (core_asleep !== v) begin
         end_sim;
      end
   endtask

   task pulse(input logic [2:0] s, input logic [1:0] m);
      @(posedge clock);
      src_event <= s;
      member_event <= m;
      @(posedge clock);
      src_event <= 3'h0;
      member_event <= 2'h0;
      #1;
   endtask

   task t_reset;
      rd(REG_CTRL, 8'hff, 8'h00);
      rd(REG_IRQ_EN, 8'hff, 8'h00);
      rd(REG_IRQ_FLAG, 8'hff, 8'h00);
      rd(REG_WORK, 8'hff, 8'h00);
      rd(8'h20, 8'hff, 8'h00);
   endtask

   task t_program;
      logic [PC_W-1:0] p;
      wait_pc(10'h021, 0);
      wait_pc(10'h022, 4);
      wait_pc(10'h023, 4);
      wait_pc(10'h024, 0);
      rd(REG_WORK, 8'hff, 8'h59);
      rd(REG_STATUS, 8'h02, 8'h02);
      wait_pc(10'h026, 0);
      rd(REG_WORK, 8'hff, 8'h5a);
      wait_pc(10'h02a, 0);
      rd(REG_WORK, 8'hff, 8'h59);
      wait_pc(10'h02b, 0);
      rd(REG_STATUS, 8'h04, 8'h04);
      wait_pc(10'h02c, 0);
      wait_pc(10'h030, 4);
      wait_pc(10'h031, 4);
      wait_pc(10'h040, 4);
      wait_pc(10'h041, 4);
      wait_pc(10'h045, 0);
      wait_pc(10'h050, 4);
      wait_pc(10'h046, 4);
      wait_pc(10'h047, 4);
      rd(REG_WORK, 8'hff, 8'h82);
      wait_pc(10'h048, 0);
      rd(REG_WORK, 8'hff, 8'hc1);
      rd(REG_STATUS, 8'h02, 8'h00);
      wait_pc(10'h049, 0);
      wait_pc(10'h031, 4);
      wait_pc(10'h032, 4);
      rd(REG_WORK, 8'hff, 8'h5a);
      wait_sleep(1'b1);
      p = prog_addr;
      repeat (8) @(posedge clock);
      #1;
      chk({6'h00, prog_addr}, {6'h00, p});
   endtask

   task t_group_irq;
      pulse(3'h0, 2'h1);
      wait_sleep(1'b0);
      rd(REG_IRQ_FLAG, 8'hff, 8'h08);
      rd(REG_MEMBER, 8'hff, 8'h01);
      wr(REG_IRQ_EN, 8'h08);
      rd(REG_IRQ_FLAG, 8'hff, 8'h08);
      wr(REG_CTRL, 8'h01);
      wait_pc(VEC_BASE + 10'h00c, 0);
      rd(REG_CTRL, 8'h01, 8'h00);
      rd(REG_IRQ_FLAG, 8'hff, 8'h00);
      rd(REG_MEMBER, 8'hff, 8'h01);
      wait_pc(10'h034, 0);
      rd(REG_CTRL, 8'h01, 8'h01);
      rd(REG_WORK, 8'hff, 8'h5a);
   endtask

   task t_plain_ret;
      wr(REG_IRQ_EN, 8'h09);
      pulse(3'h1, 2'h0);
      wait_pc(VEC_BASE, 0);
      wait_pc(10'h034, 0);
      rd(REG_CTRL, 8'h01, 8'h00);
      rd(REG_IRQ_FLAG, 8'hff, 8'h00);
   endtask

   // a flag already high before sleep must not wake the core again
   task t_presleep;
      pulse(3'h1, 2'h0);
      // enter sleep just after the loop's jump target arrives, clear of a jump's dead cycle
      wait_pc(10'h033, 0);
      wait_pc(10'h034, 0);
      wr(REG_CTRL, 8'h02);
      wait_sleep(1'b1);
      pulse(3'h1, 2'h0);
      repeat (8) @(posedge clock);
      #1;
      chk({15'h0000, core_asleep}, 16'h0001);
      pulse(3'h2, 2'h0);
      wait_sleep(1'b0);
      rd(REG_IRQ_FLAG, 8'hff, 8'h03);
      wr(REG_IRQ_FLAG, 8'h03);
      wr(REG_MEMBER, 8'h01);
      rd(REG_IRQ_FLAG, 8'hff, 8'h00);
      rd(REG_MEMBER, 8'hff, 8'h00);
   endtask

   initial begin
      for (int i = 0; i < 1024; i++) begin
         prog[i] = 16'h0000;
      end
      prog[10'h000] = 16'hc020;
      // service routines hold no call, so one stack level always stays free
      prog[10'h004] = 16'h0100;
      prog[10'h010] = 16'h0200;
      prog[10'h020] = 16'h305a;
      prog[10'h021] = 16'h2010;
      prog[10'h022] = 16'h60ff;
      prog[10'h023] = 16'h5810;
      prog[10'h024] = 16'h4910;
      prog[10'h025] = 16'h8110;
      prog[10'h026] = 16'h1010;
      prog[10'h027] = 16'ha110;
      // executing this word would load ff and show that the skip failed
      prog[10'h028] = 16'h30ff;
      prog[10'h029] = 16'h6400;
      prog[10'h02a] = 16'h3030;
      prog[10'h02b] = 16'h2002;
      prog[10'h030] = 16'hd040;
      prog[10'h031] = 16'h0300;
      prog[10'h033] = 16'hc033;
      prog[10'h040] = 16'h3000;
      prog[10'h041] = 16'h2008;
      prog[10'h042] = 16'h3050;
      prog[10'h043] = 16'h2007;
      prog[10'h044] = 16'he011;
      prog[10'h045] = 16'h1011;
      prog[10'h046] = 16'h4c11;
      prog[10'h047] = 16'h1009;
      prog[10'h048] = 16'h0100;
      prog[10'h050] = 16'h5a82;
      repeat (6) @(posedge clock);
      sys_rst <= 1'b0;
      t_reset;
      t_program;
      t_group_irq;
      t_plain_ret;
      t_presleep;
      end_sim;
   end
endmodule
